// file: hw/mswc_pkg.sv
`default_nettype none
package mswc_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_MANUAL_LINE_ROUTING = 8'h13;
  localparam logic [7:0] IDX_MANUAL_AUX_OUTPUTS = 8'h14;
  localparam logic [7:0] IDX_SOFT_RESET_CONTROL = 8'h1B;
  localparam logic [7:0] IDX_ROUTING_CONTROL = 8'h02;
  localparam logic [7:0] IDX_ROUTING_STATUS = 8'h20;

  // Field positions
  localparam int MINUS_HI = 7;
  localparam int MINUS_LO = 5;
  localparam int PLUS_HI = 4;
  localparam int PLUS_LO = 2;
  localparam int BOOT_BIT = 3;
  localparam int FACTORY_BIT = 2;
  localparam int SOFT_RESET_BIT = 0;
  localparam int AUTO_CONFIG_BIT = 2;
  localparam int SWITCH_OPEN_BIT = 4;

  // Routing codes
  localparam logic [2:0] ROUTE_OPEN = 3'h0;
  localparam logic [2:0] ROUTE_USB = 3'h1;
  localparam logic [2:0] ROUTE_UART = 3'h3;

  // Reset values
  localparam logic [7:0] RST_LINE_ROUTING = 8'h00;
  localparam logic [7:0] RST_AUX_OUTPUTS = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h04;

  // Pulse width of the internal soft reset, in pclk cycles
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h4;

  typedef struct packed {
    logic usb;
    logic uart;
  } mswc_route_t;

  typedef struct packed {
    mswc_route_t minus_line;
    mswc_route_t plus_line;
  } mswc_switch_t;

endpackage : mswc_pkg
`default_nettype wire

// file: hw/mswc_regs.sv
// Operation
// - Minus-line field bits 7:5: 000 open, 001 USB host, 011 UART host.
// - Plus-line field bits 4:2: 000 open, 001 USB host, 011 UART host.
// - Manual routing applies only after an accessory has been attached.
// - Aux bit 2 drives factory output: open-drain pulls low, push-pull drives level.
// - Writing 1 to reset bit 0 resets the device; 0 does nothing.
// - With control bit 4 set, bit 2 set selects automatic routing, cleared selects manual; bit 4 clear holds all lines open.
`timescale 1ns/1ps
`default_nettype none
module mswc_regs #(
  parameter bit OPEN_DRAIN = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic accessory_attached,
  input wire logic [1:0] auto_minus_route,
  input wire logic [1:0] auto_plus_route,
  output mswc_pkg::mswc_switch_t switch_ff,
  output logic boot_level_select,
  output logic factory_out,
  output logic factory_oe,
  output logic device_reset
);

  logic [7:0] line_ff;
  logic [7:0] aux_ff;
  logic [7:0] ctrl_ff;
  logic [3:0] srst_cnt_ff;
  logic [2:0] att_sync_ff;
  logic attached_ff;
  logic seen_attach_ff;
  logic soft_rst;
  logic access;
  logic wr;
  logic [9:0] idx;
  logic addr_ok;
  mswc_pkg::mswc_route_t dec_minus;
  mswc_pkg::mswc_route_t dec_plus;
  mswc_pkg::mswc_switch_t nxt_switch;
  logic [31:0] nxt_rdata;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign idx = paddr[11:2];
  assign soft_rst = srst_cnt_ff != 4'h0;

  always_comb begin
    addr_ok = (paddr[1:0] == 2'h0);
    if (idx == {2'h0, mswc_pkg::IDX_MANUAL_LINE_ROUTING}) begin
      nxt_rdata = {24'h0, line_ff};
    end else if (idx == {2'h0, mswc_pkg::IDX_MANUAL_AUX_OUTPUTS}) begin
      nxt_rdata = {24'h0, aux_ff};
    end else if (idx == {2'h0, mswc_pkg::IDX_SOFT_RESET_CONTROL}) begin
      nxt_rdata = 32'h0;
    end else if (idx == {2'h0, mswc_pkg::IDX_ROUTING_CONTROL}) begin
      nxt_rdata = {24'h0, ctrl_ff};
    end else if (idx == {2'h0, mswc_pkg::IDX_ROUTING_STATUS}) begin
      nxt_rdata = {26'h0, seen_attach_ff, attached_ff, nxt_switch};
    end else begin
      nxt_rdata = 32'h0;
      addr_ok = 1'b0;
    end
  end

  // Zero-wait slave: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? nxt_rdata : 32'h0;
    end
  end

  // Registers take a write only at the completing edge
  logic wr_ok;
  assign wr_ok = wr && pready && addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ff <= mswc_pkg::RST_LINE_ROUTING;
    end else if (soft_rst) begin
      line_ff <= mswc_pkg::RST_LINE_ROUTING;
    end else if (wr_ok && idx == {2'h0, mswc_pkg::IDX_MANUAL_LINE_ROUTING}) begin
      line_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ff <= mswc_pkg::RST_AUX_OUTPUTS;
    end else if (soft_rst) begin
      aux_ff <= mswc_pkg::RST_AUX_OUTPUTS;
    end else if (wr_ok && idx == {2'h0, mswc_pkg::IDX_MANUAL_AUX_OUTPUTS}) begin
      aux_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= mswc_pkg::RST_CONTROL;
    end else if (soft_rst) begin
      ctrl_ff <= mswc_pkg::RST_CONTROL;
    end else if (wr_ok && idx == {2'h0, mswc_pkg::IDX_ROUTING_CONTROL}) begin
      ctrl_ff <= pwdata[7:0];
    end
  end

  // Soft reset: a write of 1 starts a short internal pulse; 0 is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_cnt_ff <= 4'h0;
    end else if (wr_ok && idx == {2'h0, mswc_pkg::IDX_SOFT_RESET_CONTROL}
                 && pwdata[mswc_pkg::SOFT_RESET_BIT]) begin
      srst_cnt_ff <= mswc_pkg::SOFT_RESET_CYCLES;
    end else if (soft_rst) begin
      srst_cnt_ff <= srst_cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= soft_rst;
    end
  end

  // Attach comes from the detector on another timing; three stages, last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_sync_ff <= 3'h0;
      attached_ff <= 1'b0;
    end else begin
      att_sync_ff <= {att_sync_ff[1:0], accessory_attached};
      if (att_sync_ff[2] == att_sync_ff[1]) begin
        attached_ff <= att_sync_ff[1];
      end
    end
  end

  // Cleared on detach so manual modes need a fresh attach
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_attach_ff <= 1'b0;
    end else if (soft_rst) begin
      seen_attach_ff <= 1'b0;
    end else begin
      seen_attach_ff <= attached_ff;
    end
  end

  mswc_route_decode u_minus (
    .code(line_ff[mswc_pkg::MINUS_HI:mswc_pkg::MINUS_LO]),
    .route(dec_minus)
  );

  mswc_route_decode u_plus (
    .code(line_ff[mswc_pkg::PLUS_HI:mswc_pkg::PLUS_LO]),
    .route(dec_plus)
  );

  always_comb begin
    nxt_switch = '0;
    if (ctrl_ff[mswc_pkg::SWITCH_OPEN_BIT] == 1'b0) begin
      nxt_switch = '0;
    end else if (ctrl_ff[mswc_pkg::AUTO_CONFIG_BIT]) begin
      nxt_switch.minus_line = auto_minus_route;
      nxt_switch.plus_line = auto_plus_route;
    end else if (seen_attach_ff) begin
      nxt_switch.minus_line = dec_minus;
      nxt_switch.plus_line = dec_plus;
    end
  end

  // Host is trusted to pass through open between configurations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_ff <= '0;
    end else begin
      switch_ff <= nxt_switch;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_level_select <= 1'b0;
      factory_out <= 1'b0;
      factory_oe <= 1'b0;
    end else begin
      boot_level_select <= aux_ff[mswc_pkg::BOOT_BIT];
      if (OPEN_DRAIN) begin
        factory_out <= 1'b0;
        factory_oe <= aux_ff[mswc_pkg::FACTORY_BIT];
      end else begin
        factory_out <= aux_ff[mswc_pkg::FACTORY_BIT];
        factory_oe <= 1'b1;
      end
    end
  end

  chk_manual_needs_attach: assert property (@(posedge pclk) disable iff (!presetn)
    !seen_attach_ff && !ctrl_ff[mswc_pkg::AUTO_CONFIG_BIT] |=> switch_ff == '0)
    else $error("manual routing applied without attach");
  chk_minus_usb: assert property (@(posedge pclk) disable iff (!presetn)
    seen_attach_ff && ctrl_ff[mswc_pkg::SWITCH_OPEN_BIT]
    && !ctrl_ff[mswc_pkg::AUTO_CONFIG_BIT]
    && line_ff[mswc_pkg::MINUS_HI:mswc_pkg::MINUS_LO] == mswc_pkg::ROUTE_USB
    |=> switch_ff.minus_line.usb)
    else $error("minus line not on usb host");
  chk_plus_uart: assert property (@(posedge pclk) disable iff (!presetn)
    seen_attach_ff && ctrl_ff[mswc_pkg::SWITCH_OPEN_BIT]
    && !ctrl_ff[mswc_pkg::AUTO_CONFIG_BIT]
    && line_ff[mswc_pkg::PLUS_HI:mswc_pkg::PLUS_LO] == mswc_pkg::ROUTE_UART
    |=> switch_ff.plus_line.uart)
    else $error("plus line not on uart host");
  chk_boot_level: assert property (@(posedge pclk) disable iff (!presetn)
    boot_level_select == $past(aux_ff[mswc_pkg::BOOT_BIT]))
    else $error("boot level mismatch");
  chk_factory_drive: assert property (@(posedge pclk) disable iff (!presetn)
    OPEN_DRAIN |-> (factory_oe == $past(aux_ff[mswc_pkg::FACTORY_BIT])) && !factory_out)
    else $error("factory output drive wrong");
  // First edge after release still shows the reset value of the enable
  chk_factory_push: assert property (@(posedge pclk) disable iff (!presetn)
    !OPEN_DRAIN && $past(presetn)
    |-> factory_oe && (factory_out == $past(aux_ff[mswc_pkg::FACTORY_BIT])))
    else $error("push-pull factory drive wrong");
  chk_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && idx == {2'h0, mswc_pkg::IDX_SOFT_RESET_CONTROL}
    && pwdata[mswc_pkg::SOFT_RESET_BIT]
    |=> ##1 device_reset [*4] ##1 !device_reset)
    else $error("soft reset pulse wrong");
  chk_reset_zero: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && idx == {2'h0, mswc_pkg::IDX_SOFT_RESET_CONTROL}
    && !pwdata[mswc_pkg::SOFT_RESET_BIT] && !soft_rst |=> ##1 !device_reset)
    else $error("zero write caused reset");
  chk_auto_route: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[mswc_pkg::SWITCH_OPEN_BIT] && ctrl_ff[mswc_pkg::AUTO_CONFIG_BIT]
    |=> switch_ff.minus_line == $past(auto_minus_route))
    else $error("auto routing not followed");

endmodule : mswc_regs
`default_nettype wire

// file: hw/mswc_route_decode.sv
`timescale 1ns/1ps
`default_nettype none
module mswc_route_decode (
  input wire logic [2:0] code,
  output mswc_pkg::mswc_route_t route
);
  // Unused codes leave the line open; safer than guessing a path
  always_comb begin
    route = '0;
    if (code == mswc_pkg::ROUTE_USB) begin
      route.usb = 1'b1;
    end else if (code == mswc_pkg::ROUTE_UART) begin
      route.uart = 1'b1;
    end
  end
endmodule : mswc_route_decode
`default_nettype wire

// file: verif/mswc_host.sv
`timescale 1ns/1ps
`default_nettype none
module mswc_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Request held until pready is seen at an edge; one idle edge after release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit of its own; the bench timeout ends a hung slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : mswc_host
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A_LR = {2'b00, mswc_pkg::IDX_MANUAL_LINE_ROUTING, 2'b00};
  localparam logic [11:0] A_AX = {2'b00, mswc_pkg::IDX_MANUAL_AUX_OUTPUTS, 2'b00};
  localparam logic [11:0] A_RS = {2'b00, mswc_pkg::IDX_SOFT_RESET_CONTROL, 2'b00};
  localparam logic [11:0] A_CT = {2'b00, mswc_pkg::IDX_ROUTING_CONTROL, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic att = 1'b0;
  logic [1:0] amr = 2'h0;
  logic [1:0] apr = 2'h0;
  logic psel, penable, pwrite, pready, pslverr, boot, fout, foe, dres, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mswc_pkg::mswc_switch_t sw;
  logic fout_pp, foe_pp;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // Rows: routing byte written, switch pattern expected (last row is an unused code)
  logic [7:0] rv [6] = '{8'h24, 8'h6C, 8'h2C, 8'h64, 8'h00, 8'h54};
  logic [3:0] rs [6] = '{4'hA, 4'h5, 4'h9, 4'h6, 4'h0, 4'h0};
  always #12.5 pclk = ~pclk;
  mswc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accessory_attached(att), .auto_minus_route(amr),
    .auto_plus_route(apr), .switch_ff(sw), .boot_level_select(boot), .factory_out(fout),
    .factory_oe(foe), .device_reset(dres));
  mswc_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Push-pull variant shares the bus; only its factory pins are watched
  mswc_regs #(.OPEN_DRAIN(1'b0)) dut_pp_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .accessory_attached(att), .auto_minus_route(amr),
    .auto_plus_route(apr), .switch_ff(), .boot_level_select(), .factory_out(fout_pp),
    .factory_oe(foe_pp), .device_reset());
  task cmp(input string s, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", s, x, g);
    end
  endtask : cmp
  task wr(input logic [11:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h0, d}, rd, e);
  endtask : wr
  task rchk(input string s, input logic [11:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0, rd, e);
    cmp(s, x, rd);
  endtask : rchk
  task settle;
    repeat (4) @(posedge pclk);
  endtask : settle
  task conclude;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // Ceiling well above the roughly two hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("control", A_CT, {24'h0, mswc_pkg::RST_CONTROL});
    rchk("routing", A_LR, 32'h0);
    wr(A_CT, 8'h10);
    wr(A_LR, 8'h24);
    settle();
    cmp("switch before attach", 32'h0, sw);
    att <= 1'b1;
    settle();
    for (int i = 0; i < 6; i++) begin
      wr(A_LR, 8'h00);
      wr(A_LR, rv[i]);
      settle();
      cmp("switch", {28'h0, rs[i]}, sw);
      rchk("routing readback", A_LR, {24'h0, rv[i]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(A_AX, {4'h0, 2'(i), 2'b00});
      settle();
      cmp("boot level", 32'(i / 2), boot);
      cmp("factory out,oe", 32'(i % 2), {fout, foe});
      cmp("push-pull out,oe", 32'(2 * (i % 2) + 1), {fout_pp, foe_pp});
    end
    amr <= 2'b10;
    apr <= 2'b01;
    wr(A_CT, 8'h14);
    settle();
    cmp("auto switch", 32'h9, sw);
    host_u.xfer(1'b0, 12'hFFC, 32'h0, rd, e);
    cmp("unmapped error", 32'h1, e);
    cmp("unmapped data", 32'h0, rd);
    host_u.xfer(1'b1, A_LR | 12'h001, 32'hFF, rd, e);
    cmp("misaligned error", 32'h1, e);
    rchk("routing after refused write", A_LR, {24'h0, rv[5]});
    wr(A_RS, 8'h00);
    n = 0;
    repeat (10) @(posedge pclk) n += int'(dres === 1'b1);
    cmp("reset on zero", 32'h0, n);
    rchk("aux kept on zero", A_AX, 32'h0C);
    wr(A_RS, 8'h01);
    n = 0;
    repeat (12) @(posedge pclk) n += int'(dres === 1'b1);
    cmp("reset width", 32'(mswc_pkg::SOFT_RESET_CYCLES), n);
    rchk("aux after reset", A_AX, 32'h0);
    rchk("control after reset", A_CT, {24'h0, mswc_pkg::RST_CONTROL});
    cmp("switch after reset", 32'h0, sw);
    cmp("boot after reset", 32'h0, boot);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
